// ---- common/pbo_pkg.sv ----
// Package for the port B override block: register map, reset values, carriers.
// Assumes one 32-bit classic Wishbone bus; every register sits in the low byte of its word.
package pbo_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_B_PINS = 8'h16;
	localparam logic [7:0] IDX_B_DIR  = 8'h17;
	localparam logic [7:0] IDX_B_OUT  = 8'h18;
	localparam logic [7:0] IDX_A_PINS = 8'h19;
	localparam logic [7:0] IDX_A_DIR  = 8'h1a;
	localparam logic [7:0] IDX_A_OUT  = 8'h1b;
	localparam logic [7:0] IDX_CTRL   = 8'h1c;

	// Reset values
	localparam logic [7:0] RST_B_DIR  = 8'h00;
	localparam logic [7:0] RST_B_OUT  = 8'h00;
	localparam logic [7:0] RST_A_DIR  = 8'h00;
	localparam logic [7:0] RST_A_OUT  = 8'h00;
	localparam logic [7:0] RST_CTRL   = 8'h00;

	// Field positions and masks
	localparam int         CTRL_PUD_BIT = 6;
	localparam logic [7:0] CTRL_WMASK   = 8'hfc;
	localparam logic [7:0] B_WMASK      = 8'h0f;
	localparam int         PIN_DBG      = 3;
	localparam int         PIN_CKO      = 2;

	// System clock source as chosen by the clock fuses
	typedef enum logic [1:0] {
		PBO_CLK_RC,
		PBO_CLK_EXT,
		PBO_CLK_XTAL,
		PBO_CLK_LFXTAL
	} pbo_clk_src_t;

	// Override enables and values of one pin
	typedef struct packed {
		logic pullup_ovr_en;
		logic pullup_ovr_val;
		logic dir_ovr_en;
		logic dir_ovr_val;
		logic outval_ovr_en;
		logic outval_ovr_val;
		logic inen_ovr_en;
		logic inen_ovr_val;
	} pbo_ovr_t;
endpackage

// ---- core/pbo_port_b_ovr.sv ----
// Port B alternate-function override logic with port A/B registers on Wishbone.
// Assumes static fuse inputs, timer and interrupt controls on clk_sys, pins asynchronous.
// Behaviour
// - Clock on pin 0 disables its I/O
// - Pin 1 is crystal output only for crystal
// - Crystal and external-clock flags follow clock source
// - Pins 0-3 are change sources 8-11
// - Clock-out fuse drives clock on pin 2
// - Clock keeps appearing on pin 2 in reset
// - Pin 2 value: clock, else compare wave
// - Interrupt or change source enables pin 2 input
// - Unprogrammed reset fuse makes pin 3 reset when the debug link is off
// - Reset-disable flag is inverted fuse bit
// - Debug fuse with lock bits unprogrammed makes pin 3 open-drain line
// - Global pull-up off bit kills pull-ups, not the pin 3 reset/debug pull-up
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps

module pbo_port_b_ovr #(
	parameter int PA_W = 8
) (
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [9:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire pbo_pkg::pbo_clk_src_t clk_src,
	input  wire logic                  deep_sleep_active,
	input  wire logic                  sysclk_out_fuse,
	input  wire logic                  reset_pin_off_fuse,
	input  wire logic                  debug_link_fuse,
	input  wire logic                  lock_bits_unprog,
	input  wire logic                  timer0_match_a_wave,
	input  wire logic                  timer0_match_a_en,
	input  wire logic                  ext_irq_zero,
	input  wire logic [3:0]            pinchg_mask,
	input  wire logic                  pinchg_group1_en,
	input  wire logic                  debug_tx_low,
	input  wire logic [3:0]            pb_in,
	output logic      [3:0]            pb_out,
	output logic      [3:0]            pb_oe_n,
	output logic      [3:0]            pb_pull,
	output logic      [3:0]            pb_inen,
	output logic      [3:0]            pb_level,
	input  wire logic [PA_W-1:0]       pa_in,
	output logic      [PA_W-1:0]       pa_out,
	output logic      [PA_W-1:0]       pa_oe_n,
	output logic      [PA_W-1:0]       pa_pull,
	output logic                       reset_pin_low,
	output logic                       debug_line_rx,
	output logic                       crystal_selected,
	output logic                       extclk_selected,
	output logic                       reset_pin_off,
	output logic                       debug_link_active
);

	initial begin
		if (PA_W < 1 || PA_W > 8) begin
			$error("PA_W must lie in 1..8");
		end
	end

	logic [7:0]            controller_control;
	logic [3:0]            port_b_output_latch;
	logic [3:0]            port_b_direction;
	logic [PA_W-1:0]       port_a_output_latch;
	logic [PA_W-1:0]       port_a_direction;
	logic [3:0]            pb_meta;
	logic [3:0]            pb_sync;
	logic [PA_W-1:0]       pa_meta;
	logic [PA_W-1:0]       pa_sync;
	logic                  pullup_global_off;
	logic                  sysclk_out_en;
	logic                  reset_pin_used;
	logic [3:0]            pinchg_on;
	logic [3:0]            b_dir;
	logic [3:0]            b_val;
	pbo_pkg::pbo_ovr_t     ovr [4];
	logic                  req;
	logic                  wr;
	logic [7:0]            idx;
	logic [7:0]            wbyte;
	logic [7:0]            next_rdata;

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target,
			input logic w);
		wr_hit = w && (a == target);
	endfunction

	// Pins are asynchronous; only the second stage is read by logic
	always_ff @(posedge clk_sys) begin
		pb_meta <= pb_in;
		pb_sync <= pb_meta;
		pa_meta <= pa_in;
		pa_sync <= pa_meta;
	end

	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr    = req && wb_we_i && wb_sel_i[0];
	assign idx   = wb_adr_i[9:2];
	assign wbyte = wb_dat_i[7:0];

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			controller_control <= pbo_pkg::RST_CTRL;
		end else if (wr_hit(idx, pbo_pkg::IDX_CTRL, wr)) begin
			controller_control <= wbyte & pbo_pkg::CTRL_WMASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port_b_output_latch <= pbo_pkg::RST_B_OUT[3:0];
		end else if (wr_hit(idx, pbo_pkg::IDX_B_OUT, wr)) begin
			port_b_output_latch <= wbyte[3:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port_b_direction <= pbo_pkg::RST_B_DIR[3:0];
		end else if (wr_hit(idx, pbo_pkg::IDX_B_DIR, wr)) begin
			port_b_direction <= wbyte[3:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port_a_output_latch <= pbo_pkg::RST_A_OUT[PA_W-1:0];
		end else if (wr_hit(idx, pbo_pkg::IDX_A_OUT, wr)) begin
			port_a_output_latch <= wbyte[PA_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port_a_direction <= pbo_pkg::RST_A_DIR[PA_W-1:0];
		end else if (wr_hit(idx, pbo_pkg::IDX_A_DIR, wr)) begin
			port_a_direction <= wbyte[PA_W-1:0];
		end
	end

	// Read mux; unmapped indices read zero and still get an ack
	always_comb begin
		next_rdata = 8'h00;
		if (idx == pbo_pkg::IDX_B_PINS) begin
			next_rdata = {4'h0, pb_sync};
		end else if (idx == pbo_pkg::IDX_B_DIR) begin
			next_rdata = {4'h0, port_b_direction};
		end else if (idx == pbo_pkg::IDX_B_OUT) begin
			next_rdata = {4'h0, port_b_output_latch};
		end else if (idx == pbo_pkg::IDX_A_PINS) begin
			next_rdata[PA_W-1:0] = pa_sync;
		end else if (idx == pbo_pkg::IDX_A_DIR) begin
			next_rdata[PA_W-1:0] = port_a_direction;
		end else if (idx == pbo_pkg::IDX_A_OUT) begin
			next_rdata[PA_W-1:0] = port_a_output_latch;
		end else if (idx == pbo_pkg::IDX_CTRL) begin
			next_rdata = controller_control;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? {24'h00_0000, next_rdata} : 32'h0000_0000;
		end
	end

	assign pullup_global_off = controller_control[pbo_pkg::CTRL_PUD_BIT];

	// Fuse bits read 0 when programmed
	assign crystal_selected  = (clk_src == pbo_pkg::PBO_CLK_XTAL) ||
		(clk_src == pbo_pkg::PBO_CLK_LFXTAL);
	assign extclk_selected   = (clk_src == pbo_pkg::PBO_CLK_EXT);
	assign reset_pin_off     = !reset_pin_off_fuse;
	assign debug_link_active = !debug_link_fuse && lock_bits_unprog;
	assign sysclk_out_en     = !sysclk_out_fuse;
	assign reset_pin_used    = !reset_pin_off || debug_link_active;
	assign pinchg_on         = pinchg_mask & {4{pinchg_group1_en}};

	always_comb begin
		// Pin 0: oscillator input or external clock input
		ovr[0].pullup_ovr_en  = extclk_selected || crystal_selected;
		ovr[0].pullup_ovr_val = 1'b0;
		ovr[0].dir_ovr_en     = extclk_selected || crystal_selected;
		ovr[0].dir_ovr_val    = 1'b0;
		ovr[0].outval_ovr_en  = extclk_selected || crystal_selected;
		ovr[0].outval_ovr_val = 1'b0;
		ovr[0].inen_ovr_en    = extclk_selected || crystal_selected || pinchg_on[0];
		ovr[0].inen_ovr_val   = (extclk_selected && !deep_sleep_active) ||
			(!extclk_selected && !crystal_selected && pinchg_on[0]);
		// Pin 1: oscillator output, crystal only
		ovr[1].pullup_ovr_en  = crystal_selected;
		ovr[1].pullup_ovr_val = 1'b0;
		ovr[1].dir_ovr_en     = crystal_selected;
		ovr[1].dir_ovr_val    = 1'b0;
		ovr[1].outval_ovr_en  = crystal_selected;
		ovr[1].outval_ovr_val = 1'b0;
		ovr[1].inen_ovr_en    = crystal_selected || pinchg_on[1];
		ovr[1].inen_ovr_val   = pinchg_on[1];
		// Pin 2: clock out wins over compare wave; clk_sys is forwarded as a level
		ovr[2].pullup_ovr_en  = sysclk_out_en;
		ovr[2].pullup_ovr_val = 1'b0;
		ovr[2].dir_ovr_en     = sysclk_out_en;
		ovr[2].dir_ovr_val    = 1'b1;
		ovr[2].outval_ovr_en  = sysclk_out_en || timer0_match_a_en;
		ovr[2].outval_ovr_val = sysclk_out_en ? clk_sys : timer0_match_a_wave;
		ovr[2].inen_ovr_en    = pinchg_on[2] || ext_irq_zero;
		ovr[2].inen_ovr_val   = pinchg_on[2] || ext_irq_zero;
		// Pin 3: reset input or open-drain debug line
		ovr[3].pullup_ovr_en  = reset_pin_used;
		ovr[3].pullup_ovr_val = 1'b1;
		ovr[3].dir_ovr_en     = reset_pin_used;
		ovr[3].dir_ovr_val    = debug_link_active && debug_tx_low;
		ovr[3].outval_ovr_en  = reset_pin_used;
		ovr[3].outval_ovr_val = 1'b0;
		ovr[3].inen_ovr_en    = reset_pin_used || pinchg_on[3];
		ovr[3].inen_ovr_val   = debug_link_active || (reset_pin_off && pinchg_on[3]);
	end

	// Merge is purely combinational so reset-time overrides need no clock edge
	for (genvar i = 0; i < 4; i++) begin : g_pb
		assign b_dir[i]   = ovr[i].dir_ovr_en ? ovr[i].dir_ovr_val
			: port_b_direction[i];
		assign b_val[i]   = ovr[i].outval_ovr_en ? ovr[i].outval_ovr_val
			: port_b_output_latch[i];
		assign pb_oe_n[i] = !b_dir[i];
		assign pb_out[i]  = b_val[i];
		assign pb_pull[i] = ovr[i].pullup_ovr_en ? ovr[i].pullup_ovr_val
			: (!port_b_direction[i] && port_b_output_latch[i] && !pullup_global_off);
		assign pb_inen[i] = ovr[i].inen_ovr_en ? ovr[i].inen_ovr_val : 1'b1;
	end

	assign pb_level      = pb_sync & pb_inen;
	assign pa_out        = port_a_output_latch;
	assign pa_oe_n       = ~port_a_direction;
	assign pa_pull       = ~port_a_direction & port_a_output_latch &
		{PA_W{!pullup_global_off}};
	assign reset_pin_low = !reset_pin_off && !debug_link_active &&
		!pb_sync[pbo_pkg::PIN_DBG];
	assign debug_line_rx = debug_link_active ? pb_sync[pbo_pkg::PIN_DBG] : 1'b1;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_r01;
		(crystal_selected || extclk_selected) |-> pb_oe_n[0] && !pb_pull[0] && !pb_out[0];
	endproperty
	a_r01: assert property (p_r01) else $error("pin 0 not freed for clock");

	property p_r02;
		!crystal_selected && port_b_direction[1] |-> !pb_oe_n[1] &&
			pb_out[1] == port_b_output_latch[1];
	endproperty
	a_r02: assert property (p_r02) else $error("pin 1 not plain I/O");

	property p_r03;
		$changed(clk_src) |-> crystal_selected == clk_src[1] &&
			extclk_selected == (clk_src == pbo_pkg::PBO_CLK_EXT);
	endproperty
	a_r03: assert property (p_r03) else $error("clock source flags wrong");

	property p_r04;
		pinchg_group1_en && pinchg_mask[1] |-> pb_inen[1];
	endproperty
	a_r04: assert property (p_r04) else $error("change source input disabled");

	property p_r06;
		sysclk_out_en |-> !pb_oe_n[2] && !pb_pull[2];
	endproperty
	a_r06: assert property (p_r06) else $error("clock out pin not driven");

	property p_r07;
		@(posedge clk_sys) disable iff (1'b0) sysclk_out_en && reset |-> !pb_oe_n[2];
	endproperty
	a_r07: assert property (p_r07) else $error("clock out lost in reset");

	property p_r08;
		!sysclk_out_en && timer0_match_a_en |-> pb_out[2] == timer0_match_a_wave;
	endproperty
	a_r08: assert property (p_r08) else $error("pin 2 not compare wave");

	property p_r09;
		ext_irq_zero |-> pb_inen[2];
	endproperty
	a_r09: assert property (p_r09) else $error("pin 2 input off with irq");

	property p_r10;
		!reset_pin_off && !debug_link_active |-> pb_pull[3] && pb_oe_n[3] && !pb_inen[3];
	endproperty
	a_r10: assert property (p_r10) else $error("reset pin misconfigured");

	property p_r11;
		reset_pin_off == !reset_pin_off_fuse;
	endproperty
	a_r11: assert property (p_r11) else $error("reset-disable polarity wrong");

	property p_r12;
		debug_link_active |-> !pb_out[3] && pb_pull[3] && pb_oe_n[3] == !debug_tx_low;
	endproperty
	a_r12: assert property (p_r12) else $error("debug line not open-drain");

	property p_r13;
		wr_hit(idx, pbo_pkg::IDX_CTRL, wr) && wbyte[pbo_pkg::CTRL_PUD_BIT] |=> pa_pull == '0;
	endproperty
	a_r13: assert property (p_r13) else $error("pull-ups stay on");

	property p_r13b;
		pullup_global_off && !crystal_selected && !extclk_selected |-> !pb_pull[0];
	endproperty
	a_r13b: assert property (p_r13b) else $error("port B pull-up ignores off bit");

	property p_r10b;
		!reset_pin_off && !debug_link_active && !pb_sync[pbo_pkg::PIN_DBG] |-> reset_pin_low;
	endproperty
	a_r10b: assert property (p_r10b) else $error("reset pin low not reported");

	property p_r14;
		!sysclk_out_en |-> !pb_oe_n[2] == port_b_direction[2];
	endproperty
	a_r14: assert property (p_r14) else $error("direction override leaks");

	property p_r15;
		wb_ack_o && !wb_we_i && idx == pbo_pkg::IDX_B_PINS |->
			wb_dat_o[3:0] == $past(pb_sync);
	endproperty
	a_r15: assert property (p_r15) else $error("pin read not synced level");

	c_xtal:  cover property (crystal_selected && pinchg_on[1]);
	c_sysclk_out_fuse: cover property (sysclk_out_en && timer0_match_a_en);
	c_dbg:   cover property (debug_link_active && debug_tx_low);
	c_read:  cover property (wb_ack_o && !wb_we_i);

endmodule

// ---- tb/pbo_pins_model.sv ----
// Pad model for port A and port B: resolves each pad from drive, pull-up and bench drive.
// Assumes the bench drives a pad only where its enable bit is set.
`timescale 1ns/1ps
module pbo_pins_model (
	input  wire logic       clk_sys,
	input  wire logic [3:0] pb_out,
	input  wire logic [3:0] pb_oe_n,
	input  wire logic [3:0] pb_pull,
	input  wire logic [3:0] ext_b_en,
	input  wire logic [3:0] ext_b_val,
	input  wire logic [7:0] pa_out,
	input  wire logic [7:0] pa_oe_n,
	input  wire logic [7:0] pa_pull,
	input  wire logic [7:0] ext_a_en,
	input  wire logic [7:0] ext_a_val,
	output logic      [3:0] pb_in,
	output logic      [7:0] pa_in
);
	logic flt = 1'b0;
	// A floating pad wanders, so a stale level never passes for a held one
	always_ff @(posedge clk_sys) begin
		flt <= ~flt;
	end
	function automatic logic pad(input logic oe_n, o, pl, xe, xv, f);
		if (!oe_n)
			return xe ? (o & xv) : o;
		if (xe)
			return xv;
		return pl ? 1'b1 : f;
	endfunction
	always_comb begin
		for (int i = 0; i < 4; i++)
			pb_in[i] = pad(pb_oe_n[i], pb_out[i], pb_pull[i], ext_b_en[i], ext_b_val[i], flt ^ i[0]);
		for (int i = 0; i < 8; i++)
			pa_in[i] = pad(pa_oe_n[i], pa_out[i], pa_pull[i], ext_a_en[i], ext_a_val[i], flt ^ i[0]);
	end
endmodule

// ---- tb/pbo_port_b_ovr_tb.sv ----
// Bench for the port B override block: Wishbone register tests and pin override checks.
// Assumes the pad model above on both ports; fuses change only between scenarios.
`timescale 1ns/1ps
module pbo_port_b_ovr_tb;
	logic                  clk_sys = 1'b0, reset = 1'b1;
	logic                  wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [9:0]            wb_adr_i = '0;
	logic [3:0]            wb_sel_i = '0;
	logic [31:0]           wb_dat_i = '0, wb_dat_o, r;
	pbo_pkg::pbo_clk_src_t clk_src = pbo_pkg::PBO_CLK_RC;
	logic                  deep_sleep_active = 0, sysclk_out_fuse = 1, reset_pin_off_fuse = 1;
	logic                  debug_link_fuse = 1, lock_bits_unprog = 0, timer0_match_a_wave = 0;
	logic                  timer0_match_a_en = 0, ext_irq_zero = 0, pinchg_group1_en = 0;
	logic                  debug_tx_low = 0, reset_pin_low, debug_line_rx, crystal_selected;
	logic                  extclk_selected, reset_pin_off, debug_link_active;
	logic [3:0]            pinchg_mask = '0, xbe = '0, xbv = '0;
	logic [3:0]            pb_in, pb_out, pb_oe_n, pb_pull, pb_inen, pb_level;
	logic [7:0]            pa_in, pa_out, pa_oe_n, pa_pull, xae = '0, xav = '0;
	int                    err_total = 0, checks_done = 0;

	always #2.5 clk_sys = ~clk_sys;

	pbo_port_b_ovr dut (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .clk_src, .deep_sleep_active,
		.sysclk_out_fuse, .reset_pin_off_fuse, .debug_link_fuse, .lock_bits_unprog,
		.timer0_match_a_wave, .timer0_match_a_en, .ext_irq_zero, .pinchg_mask,
		.pinchg_group1_en, .debug_tx_low, .pb_in, .pb_out, .pb_oe_n, .pb_pull, .pb_inen,
		.pb_level, .pa_in, .pa_out, .pa_oe_n, .pa_pull, .reset_pin_low, .debug_line_rx,
		.crystal_selected, .extclk_selected, .reset_pin_off, .debug_link_active);
	pbo_pins_model pins (.clk_sys, .pb_out, .pb_oe_n, .pb_pull, .ext_b_en(xbe),
		.ext_b_val(xbv), .pa_out, .pa_oe_n, .pa_pull, .ext_a_en(xae), .ext_a_val(xav),
		.pb_in, .pa_in);

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic cycle; ack is sampled at the edge, so read data is taken there too
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n >= 20) begin
			err_total++;
			complete_run();
		end
	endtask
	task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		chk(nm, {24'h0, e}, r);
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		rd("b_dir", pbo_pkg::IDX_B_DIR, pbo_pkg::RST_B_DIR);
		rd("b_out", pbo_pkg::IDX_B_OUT, pbo_pkg::RST_B_OUT);
		rd("a_dir", pbo_pkg::IDX_A_DIR, pbo_pkg::RST_A_DIR);
		rd("a_out", pbo_pkg::IDX_A_OUT, pbo_pkg::RST_A_OUT);
		rd("ctrl", pbo_pkg::IDX_CTRL, pbo_pkg::RST_CTRL);
		wb(1'b1, 8'h30, 8'h55);
		rd("unmapped", 8'h30, 8'h00);
		wb(1'b1, pbo_pkg::IDX_B_OUT, 8'hff);
		rd("b_out", pbo_pkg::IDX_B_OUT, 8'h0f);
		wb(1'b1, pbo_pkg::IDX_A_OUT, 8'h0f);
		xae <= 8'hf0;
		xav <= 8'ha0;
		// Pad levels need two edges through the synchroniser before a read sees them
		repeat (2) @(posedge clk_sys);
		rd("a_pins", pbo_pkg::IDX_A_PINS, 8'haf);
		chk("a_pull", 8'h0f, pa_pull);
		chk("a_drive", 16'h0fff, {pa_out, pa_oe_n});
		wb(1'b1, pbo_pkg::IDX_CTRL, 8'hff);
		rd("ctrl", pbo_pkg::IDX_CTRL, 8'hfc);
		chk("a_pull_off", 8'h00, pa_pull);
		wb(1'b1, pbo_pkg::IDX_B_DIR, 8'h0f);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			clk_src <= pbo_pkg::pbo_clk_src_t'(k);
			@(negedge clk_sys);
			chk("osc_flags", {k >= 2, k == 1}, {crystal_selected, extclk_selected});
			chk("pb10", {k >= 2, k >= 1, k < 2, k < 1}, {pb_oe_n[1:0], pb_out[1:0]});
			chk("pb1_inen", k < 2, pb_inen[1]);
		end
		@(posedge clk_sys);
		pinchg_mask <= 4'h2;
		pinchg_group1_en <= 1'b1;
		@(negedge clk_sys);
		chk("pb1_chg", 1'b1, pb_inen[1]);
		@(posedge clk_sys);
		clk_src <= pbo_pkg::PBO_CLK_EXT;
		deep_sleep_active <= 1'b1;
		@(negedge clk_sys);
		chk("pb0_sleep", 1'b0, pb_inen[0]);
		@(posedge clk_sys);
		clk_src <= pbo_pkg::PBO_CLK_RC;
		sysclk_out_fuse <= 1'b0;
		timer0_match_a_en <= 1'b1;
		wb(1'b1, pbo_pkg::IDX_B_DIR, 8'h00);
		for (int k = 0; k < 2; k++) begin
			@(negedge clk_sys);
			chk("cko_lo", 3'b000, {pb_out[2], pb_oe_n[2], pb_pull[2]});
			@(posedge clk_sys);
			reset <= k == 0;
			#1;
			chk("cko_hi", 1'b1, pb_out[2]);
		end
		@(posedge clk_sys);
		reset <= 1'b0;
		sysclk_out_fuse <= 1'b1;
		ext_irq_zero <= 1'b1;
		rd("ctrl_rst", pbo_pkg::IDX_CTRL, pbo_pkg::RST_CTRL);
		wb(1'b1, pbo_pkg::IDX_B_OUT, 8'h0f);
		wb(1'b1, pbo_pkg::IDX_B_DIR, 8'h0f);
		@(negedge clk_sys);
		chk("cmp_wave", 2'b01, {pb_out[2], pb_inen[2]});
		@(posedge clk_sys);
		timer0_match_a_wave <= 1'b1;
		xbe <= 4'h8;
		@(negedge clk_sys);
		chk("cmp_wave1", 1'b1, pb_out[2]);
		chk("rst_pin", 4'b0110, {reset_pin_off, pb_pull[3], pb_oe_n[3], pb_inen[3]});
		chk("pb3_level", 1'b0, pb_level[3]);
		repeat (3) @(negedge clk_sys);
		chk("rst_low", 1'b1, reset_pin_low);
		@(posedge clk_sys);
		reset_pin_off_fuse <= 1'b0;
		debug_link_fuse <= 1'b0;
		lock_bits_unprog <= 1'b1;
		xbe <= 4'h0;
		@(negedge clk_sys);
		chk("rst_off", 1'b1, reset_pin_off);
		chk("dbg", 4'b1110, {debug_link_active, pb_pull[3], pb_oe_n[3], pb_out[3]});
		repeat (3) @(negedge clk_sys);
		chk("dbg_rx_idle", 1'b1, debug_line_rx);
		@(posedge clk_sys);
		debug_tx_low <= 1'b1;
		repeat (3) @(negedge clk_sys);
		chk("dbg_tx", 2'b00, {pb_oe_n[3], debug_line_rx});
		rd("b_pins", pbo_pkg::IDX_B_PINS, 8'h07);
		chk("pb_level", 4'h7, pb_level);
		complete_run();
	end
endmodule
